// >>> logic/sdtc_regs.svh
// Functional notes
// RL1 - Refresh count loads an interval timer; each expiry pulses a refresh burst.
// RL2 - No refresh at all until software has written the refresh count.
// RL3 - Timer reloads after each pulse, repeating while the count is nonzero.
// RL4 - Column field 00..11 selects 8..11 column bits; reset selects 8.
// RL5 - Row field 00..10 selects 11..13 row bits; 11 reserved; reset 11.
// RL6 - Bank bit 0 selects two banks, 1 selects four; reset two.
// RL7 - CAS latency codes 01,10,11 give 1..3 cycles; 00 reserved; reset 2.
// RL8 - Bus width bit 0 selects 32 bits, 1 selects 16; reset 16.
// RL9 - Write recovery lasts the programmed 0..15 cycles; reset 2.
// RL10 - Refresh to activate waits programmed 0..15 cycles; reset 7.
// RL11 - After precharge wait programmed 0..15 cycles before any command; reset 3.
// RL12 - Activate to read or write waits programmed 0..15 cycles; reset 2.
// RL13 - Activate to precharge keeps at least programmed 0..15 cycles; reset 5.
// RL14 - After clock enable rises leaving self-refresh, wait programmed cycles before activate.
// RL15 - Low-power select 00 never issues power-down, self-refresh or deep power-down.
// RL16 - Select 01 enters self-refresh, stops clock, drops clock enable; exits per access.
// RL17 - Select 10 powers down after each access, clock enable low, exits on access.
// RL18 - Select 11 issues deep power-down; meant for low-power parts only.
// RL19 - Partial array setting is handed to low-power memory during initialization.
// RL20 - Temperature refresh and drive strength settings are handed over during initialization.
// RL21 - Low-power entry after last transfer: immediately, 64 or 128 clocks; 11 reserved.
// RL22 - Writing 1 to enable register bit sets the interrupt mask; 0 no effect.
// RL23 - Writing 1 to disable register bit clears the interrupt mask; 0 no effect.
// RL24 - Refresh error sets a status flag that clears when status is read.
// RL25 - Read-only mask bit shows whether refresh error interrupt is enabled.
// RL26 - Self-refresh lasts at least the activate-to-precharge time before exit.
`ifndef SDTC_REGS_SVH
`define SDTC_REGS_SVH
`define SDTC_OFS_REFRESH    8'h04
`define SDTC_OFS_GEOMETRY   8'h08
`define SDTC_OFS_LOWPOWER   8'h10
`define SDTC_OFS_IRQ_EN     8'h14
`define SDTC_OFS_IRQ_DIS    8'h18
`define SDTC_OFS_IRQ_MASK   8'h1C
`define SDTC_OFS_IRQ_STAT   8'h20
`define SDTC_RST_REFRESH    32'h0000_0000
`define SDTC_RST_GEOMETRY   32'h8523_72C0
`define SDTC_RST_LOWPOWER   32'h0000_0000
`define SDTC_LP_TIMEOUT_64  8'h40
`define SDTC_LP_TIMEOUT_128 8'h80
`define SDTC_BIT_REFRESH_ERR 0
`endif

// >>> logic/sdtc_pkg.sv
package sdtc_pkg;
  typedef enum logic [8:0] {
    SDTC_ST_IDLE  = 9'h001,
    SDTC_ST_ACT   = 9'h002,
    SDTC_ST_XFER  = 9'h004,
    SDTC_ST_PRE   = 9'h008,
    SDTC_ST_REF   = 9'h010,
    SDTC_ST_SREF  = 9'h020,
    SDTC_ST_SRX   = 9'h040,
    SDTC_ST_PDN   = 9'h080,
    SDTC_ST_DPD   = 9'h100
  } sdtc_state_e;

  typedef enum logic [2:0] {
    SDTC_CMD_NOP    = 3'h0,
    SDTC_CMD_ACT    = 3'h1,
    SDTC_CMD_RW     = 3'h2,
    SDTC_CMD_PRE    = 3'h3,
    SDTC_CMD_REF    = 3'h4,
    SDTC_CMD_SREF   = 3'h5,
    SDTC_CMD_PDN    = 3'h6,
    SDTC_CMD_DPD    = 3'h7
  } sdtc_cmd_e;

  typedef struct packed {
    logic [3:0] col_bits;
    logic [3:0] row_bits;
    logic [2:0] banks;
    logic [1:0] cas_cycles;
    logic [5:0] bus_bits;
  } sdtc_geom_s;

  typedef struct packed {
    logic [2:0] partial_array_setting;
    logic [1:0] temp_comp_refresh_setting;
    logic [1:0] drive_strength_setting;
  } sdtc_ext_s;
endpackage : sdtc_pkg

// >>> logic/sdtc_core.sv
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "sdtc_regs.svh"
module sdtc_core
  import sdtc_pkg::*;
#(
  parameter int REF_W = 12
) (
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // Access requests from the memory port.
  input  wire logic        acc_req,
  input  wire logic        acc_write,
  output var  logic        acc_done,
  // Memory command side.
  output var  sdtc_cmd_e   mem_cmd,
  output var  logic        mem_clock_enable_out,
  output var  logic        mem_clock_run,
  // Configuration handed to the address and init logic, plus the refresh error flag and interrupt mask.
  output var  sdtc_geom_s  geom,
  output var  sdtc_ext_s   ext_mode,
  output var  logic        refresh_error_flag,
  output var  logic        refresh_irq_mask
);

  if (REF_W < 1 || REF_W > 16) begin : g_bad_ref_w
    $error("REF_W out of range");
  end

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [3:0] col_decode(input logic [1:0] code);
    col_decode = 4'(4'h8 + {2'h0, code});
  endfunction

  function automatic logic [3:0] row_decode(input logic [1:0] code);
    row_decode = (code == 2'h3) ? 4'h0 : 4'(4'hB + {2'h0, code});
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  logic [REF_W-1:0] refresh_count_ff;
  logic             refresh_written_ff;
  logic [31:0]      geom_cfg_ff;
  logic [31:0]      lp_cfg_ff;
  logic             mask_ff;
  logic             err_ff;
  logic [31:0]      prdata_ff;
  logic             pready_ff;
  logic             pslverr_ff;

  logic setup;
  logic wr_en;
  logic rd_stat;
  logic mapped;
  assign setup   = psel & ~penable;
  assign wr_en   = psel & penable & pready_ff & pwrite;
  assign rd_stat = psel & penable & pready_ff & ~pwrite & (paddr == `SDTC_OFS_IRQ_STAT);
  assign mapped  = (paddr == `SDTC_OFS_REFRESH) | (paddr == `SDTC_OFS_GEOMETRY) |
                   (paddr == `SDTC_OFS_LOWPOWER) | (paddr == `SDTC_OFS_IRQ_EN) |
                   (paddr == `SDTC_OFS_IRQ_DIS) | (paddr == `SDTC_OFS_IRQ_MASK) |
                   (paddr == `SDTC_OFS_IRQ_STAT);

  // Configuration registers take writes on the access phase.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      refresh_count_ff   <= '0;
      refresh_written_ff <= 1'b0;
      geom_cfg_ff        <= `SDTC_RST_GEOMETRY;
      lp_cfg_ff          <= `SDTC_RST_LOWPOWER;
    end else if (wr_en) begin
      if (paddr == `SDTC_OFS_REFRESH) begin
        refresh_count_ff   <= pwdata[REF_W-1:0];
        refresh_written_ff <= 1'b1; // see RL2
      end
      if (paddr == `SDTC_OFS_GEOMETRY) begin
        geom_cfg_ff <= pwdata;
      end
      if (paddr == `SDTC_OFS_LOWPOWER) begin
        lp_cfg_ff <= pwdata & 32'h0000_3F73;
      end
    end
  end

  // Interrupt mask.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mask_ff <= 1'b0;
    end else if (wr_en && paddr == `SDTC_OFS_IRQ_EN && pwdata[`SDTC_BIT_REFRESH_ERR]) begin
      mask_ff <= 1'b1; // see RL22
    end else if (wr_en && paddr == `SDTC_OFS_IRQ_DIS && pwdata[`SDTC_BIT_REFRESH_ERR]) begin
      mask_ff <= 1'b0; // see RL23
    end
  end

  // Read data and response are prepared in the setup phase.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata_ff  <= '0;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= setup;
      pslverr_ff <= setup & ~mapped;
      if (setup && !pwrite) begin
        unique case (paddr)
          `SDTC_OFS_REFRESH:  prdata_ff <= 32'(refresh_count_ff);
          `SDTC_OFS_GEOMETRY: prdata_ff <= geom_cfg_ff;
          `SDTC_OFS_LOWPOWER: prdata_ff <= lp_cfg_ff;
          `SDTC_OFS_IRQ_MASK: prdata_ff <= {31'h0, mask_ff}; // see RL25
          `SDTC_OFS_IRQ_STAT: prdata_ff <= {31'h0, err_ff};
          default:            prdata_ff <= '0;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  logic [REF_W-1:0] ref_timer_ff;
  logic             ref_pend_ff;
  logic             ref_tick;
  logic             ref_taken;
  logic             ref_drop;
  assign ref_tick = refresh_written_ff && (refresh_count_ff != '0) && (ref_timer_ff == '0);

  // Interval timer reloads on every expiry and on a new count.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ref_timer_ff <= '0;
    end else if (wr_en && paddr == `SDTC_OFS_REFRESH) begin
      ref_timer_ff <= pwdata[REF_W-1:0]; // see RL1
    end else if (ref_tick) begin
      ref_timer_ff <= refresh_count_ff; // see RL3
    end else if (refresh_written_ff && ref_timer_ff != '0) begin
      ref_timer_ff <= ref_timer_ff - 1'b1;
    end
  end

  // A tick that finds the previous burst still pending is a refresh error, except in self-refresh or deep power-down.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ref_pend_ff <= 1'b0;
      err_ff      <= 1'b0;
    end else begin
      if (ref_tick) begin
        ref_pend_ff <= 1'b1; // see RL1
      end else if (ref_taken || ref_drop) begin
        ref_pend_ff <= 1'b0;
      end
      if (ref_tick && ref_pend_ff && !ref_drop) begin
        err_ff <= 1'b1; // see RL24
      end else if (rd_stat) begin
        err_ff <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  logic [3:0] c_twr;
  logic [3:0] c_trc;
  logic [3:0] c_trp;
  logic [3:0] c_activate_to_access_cycles;
  logic [3:0] c_activate_to_precharge_cycles;
  logic [3:0] c_selfrefresh_exit_cycles;
  logic [1:0] lp_sel;
  logic [1:0] lp_tmo;
  assign c_twr  = geom_cfg_ff[11:8];
  assign c_trc  = geom_cfg_ff[15:12];
  assign c_trp  = geom_cfg_ff[19:16];
  assign c_activate_to_access_cycles = geom_cfg_ff[23:20];
  assign c_activate_to_precharge_cycles = geom_cfg_ff[27:24];
  assign c_selfrefresh_exit_cycles = geom_cfg_ff[31:28];
  assign lp_sel = lp_cfg_ff[1:0];
  assign lp_tmo = lp_cfg_ff[13:12];

  sdtc_state_e state_ff;
  sdtc_cmd_e   cmd_ff;
  logic [3:0]  wait_ff;
  logic [3:0]  ras_ff;
  logic [7:0]  idle_ff;
  logic        wr_ff;
  logic        cke_ff;
  logic        clk_run_ff;
  logic        done_ff;
  logic        lp_due;

  // Idle time since the sequencer last returned to idle or saw a request, for the low-power timeout.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      idle_ff <= '0;
    end else if (state_ff != SDTC_ST_IDLE || acc_req) begin
      idle_ff <= '0;
    end else if (idle_ff != 8'hFF) begin
      idle_ff <= idle_ff + 1'b1;
    end
  end

  always_comb begin
    unique case (lp_tmo)
      2'h0:    lp_due = 1'b1; // see RL21
      2'h1:    lp_due = (idle_ff >= `SDTC_LP_TIMEOUT_64);
      2'h2:    lp_due = (idle_ff >= `SDTC_LP_TIMEOUT_128);
      default: lp_due = 1'b0;
    endcase
  end

  assign ref_taken = (state_ff == SDTC_ST_IDLE) && ref_pend_ff;
  assign ref_drop  = (state_ff == SDTC_ST_SREF) || (state_ff == SDTC_ST_DPD);

  // Activate-to-precharge minimum, also the self-refresh minimum stay.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ras_ff <= '0;
    end else if (cmd_ff == SDTC_CMD_ACT || cmd_ff == SDTC_CMD_SREF) begin
      ras_ff <= (c_activate_to_precharge_cycles == 4'h0) ? 4'h0 : c_activate_to_precharge_cycles - 1'b1; // see RL13 RL26
    end else if (ras_ff != '0) begin
      ras_ff <= ras_ff - 1'b1;
    end
  end

  // Command sequencer.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff   <= SDTC_ST_IDLE;
      cmd_ff     <= SDTC_CMD_NOP;
      wait_ff    <= '0;
      wr_ff      <= 1'b0;
      cke_ff     <= 1'b1;
      clk_run_ff <= 1'b1;
      done_ff    <= 1'b0;
    end else begin
      cmd_ff  <= SDTC_CMD_NOP;
      done_ff <= 1'b0;
      if (wait_ff != '0) begin
        wait_ff <= wait_ff - 1'b1;
      end
      unique case (state_ff)
        SDTC_ST_IDLE: begin
          if (ref_pend_ff) begin
            cmd_ff   <= SDTC_CMD_REF;
            wait_ff  <= c_trc; // see RL10
            state_ff <= SDTC_ST_REF;
          end else if (acc_req && !done_ff) begin
            // A request still held while completion is reported is the finished one.
            cmd_ff   <= SDTC_CMD_ACT;
            wr_ff    <= acc_write;
            wait_ff  <= c_activate_to_access_cycles; // see RL12
            state_ff <= SDTC_ST_ACT;
          end else if (lp_sel != 2'h0 && lp_due) begin // see RL15
            cke_ff <= 1'b0;
            unique case (lp_sel)
              2'h1: begin
                cmd_ff     <= SDTC_CMD_SREF;
                clk_run_ff <= 1'b0; // see RL16
                state_ff   <= SDTC_ST_SREF;
              end
              2'h2: begin
                cmd_ff   <= SDTC_CMD_PDN; // see RL17
                state_ff <= SDTC_ST_PDN;
              end
              default: begin
                cmd_ff   <= SDTC_CMD_DPD; // see RL18
                state_ff <= SDTC_ST_DPD;
              end
            endcase
          end
        end
        SDTC_ST_ACT: begin
          if (wait_ff == '0) begin
            cmd_ff   <= SDTC_CMD_RW;
            wait_ff  <= wr_ff ? c_twr : {2'h0, geom_cfg_ff[6:5]}; // see RL9 RL7
            state_ff <= SDTC_ST_XFER;
          end
        end
        SDTC_ST_XFER: begin
          if (wait_ff == '0 && ras_ff == '0) begin
            cmd_ff   <= SDTC_CMD_PRE; // see RL13
            wait_ff  <= c_trp; // see RL11
            state_ff <= SDTC_ST_PRE;
          end
        end
        SDTC_ST_PRE, SDTC_ST_REF: begin
          if (wait_ff == '0) begin
            done_ff  <= (state_ff == SDTC_ST_PRE);
            state_ff <= SDTC_ST_IDLE;
          end
        end
        SDTC_ST_SREF: begin
          if (acc_req && ras_ff == '0) begin
            cke_ff     <= 1'b1;
            clk_run_ff <= 1'b1;
            wait_ff    <= c_selfrefresh_exit_cycles; // see RL14
            state_ff   <= SDTC_ST_SRX;
          end
        end
        SDTC_ST_SRX: begin
          if (wait_ff == '0) begin
            state_ff <= SDTC_ST_IDLE;
          end
        end
        SDTC_ST_PDN: begin
          if (acc_req || ref_pend_ff || lp_sel != 2'h2) begin
            cke_ff   <= 1'b1; // see RL17
            state_ff <= SDTC_ST_IDLE;
          end
        end
        SDTC_ST_DPD: begin
          if (lp_sel != 2'h3) begin
            cke_ff   <= 1'b1;
            state_ff <= SDTC_ST_IDLE;
          end
        end
        default: begin
          state_ff <= SDTC_ST_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  sdtc_geom_s geom_ff;
  sdtc_ext_s  ext_ff;
  logic       err_out_ff;
  logic       mask_out_ff;

  // Decoded geometry and low-power memory settings, registered for output.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      geom_ff     <= '0;
      ext_ff      <= '0;
      err_out_ff  <= 1'b0;
      mask_out_ff <= 1'b0;
    end else begin
      geom_ff.col_bits   <= col_decode(geom_cfg_ff[1:0]); // see RL4
      geom_ff.row_bits   <= row_decode(geom_cfg_ff[3:2]); // see RL5
      geom_ff.banks      <= geom_cfg_ff[4] ? 3'h4 : 3'h2; // see RL6
      geom_ff.cas_cycles <= geom_cfg_ff[6:5]; // see RL7
      geom_ff.bus_bits   <= geom_cfg_ff[7] ? 6'h10 : 6'h20; // see RL8
      ext_ff.partial_array_setting     <= lp_cfg_ff[6:4]; // see RL19
      ext_ff.temp_comp_refresh_setting <= lp_cfg_ff[9:8]; // see RL20
      ext_ff.drive_strength_setting    <= lp_cfg_ff[11:10]; // see RL20
      err_out_ff  <= err_ff;
      mask_out_ff <= mask_ff;
    end
  end

  assign prdata               = prdata_ff;
  assign pready               = pready_ff;
  assign pslverr              = pslverr_ff;
  assign acc_done             = done_ff;
  assign mem_cmd              = cmd_ff;
  assign mem_clock_enable_out = cke_ff;
  assign mem_clock_run        = clk_run_ff;
  assign geom                 = geom_ff;
  assign ext_mode             = ext_ff;
  assign refresh_error_flag   = err_out_ff;
  assign refresh_irq_mask     = mask_out_ff;

endmodule // sdtc_core
`default_nettype wire

// >>> sim/sdtc_core_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module sdtc_core_asserts
  import sdtc_pkg::*;
(
  // Clock, reset and register bus.
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Memory command side.
  input wire sdtc_cmd_e   mem_cmd,
  input wire logic        mem_clock_enable_out,
  input wire logic        mem_clock_run
);
  logic        wr;
  logic [31:0] cfg_ff;
  logic [1:0]  lp_ff;
  logic        armed_ff;
  logic [4:0]  act_ff;
  logic [4:0]  pre_ff;
  logic [4:0]  ref_ff;
  logic [3:0]  trp_ff;
  logic [3:0]  trc_ff;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  assign wr = psel && penable && pready && pwrite;

  function automatic logic [4:0] since(logic [4:0] c, logic hit);
    return hit ? 5'h01 : ((c == 5'h1F) ? c : c + 5'h01);
  endfunction

  // Mirrors of the settings that the checks depend on.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_ff   <= 32'h852372C0;
      lp_ff    <= 2'h0;
      armed_ff <= 1'b0;
    end else if (wr) begin
      if (paddr == 8'h08) cfg_ff <= pwdata;
      if (paddr == 8'h10) lp_ff <= pwdata[1:0];
      if (paddr == 8'h04 && pwdata[11:0] != 12'h000) armed_ff <= 1'b1;
    end
  end

  // Cycles since the last activate, precharge and refresh command.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      act_ff <= 5'h1F;
      pre_ff <= 5'h1F;
      ref_ff <= 5'h1F;
      trp_ff <= 4'h0;
      trc_ff <= 4'h0;
    end else begin
      act_ff <= since(act_ff, mem_cmd == SDTC_CMD_ACT);
      pre_ff <= since(pre_ff, mem_cmd == SDTC_CMD_PRE);
      ref_ff <= since(ref_ff, mem_cmd == SDTC_CMD_REF);
      // The delay owed is the one programmed when the command went out.
      if (mem_cmd == SDTC_CMD_PRE) trp_ff <= cfg_ff[19:16];
      if (mem_cmd == SDTC_CMD_REF) trc_ff <= cfg_ff[15:12];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  chk_ready_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  chk_ready_only: assert property (pready |-> psel && penable && $past(psel && !penable))
    else $error("pready outside access phase");
  chk_err_unmapped: assert property (pready |-> pslverr == !(paddr inside
    {8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20}))
    else $error("pslverr wrong for address");
  chk_no_early_ref: assert property (!armed_ff |-> mem_cmd != SDTC_CMD_REF)
    else $error("refresh before count written");
  chk_lp_off: assert property (lp_ff == 2'h0 |-> !(mem_cmd inside
    {SDTC_CMD_SREF, SDTC_CMD_PDN, SDTC_CMD_DPD}))
    else $error("low power command while inhibited");
  chk_lp_cke_low: assert property (mem_cmd inside
    {SDTC_CMD_SREF, SDTC_CMD_PDN, SDTC_CMD_DPD} |-> !mem_clock_enable_out)
    else $error("clock enable high on low power entry");
  chk_sref_clk_stop: assert property (mem_cmd == SDTC_CMD_SREF |-> ##[0:1] !mem_clock_run)
    else $error("memory clock still running in self-refresh");
  chk_rcd_delay: assert property (mem_cmd == SDTC_CMD_RW |-> act_ff == cfg_ff[23:20] + 5'h01)
    else $error("activate to access delay wrong");
  chk_ras_delay: assert property (mem_cmd == SDTC_CMD_PRE |-> act_ff >= cfg_ff[27:24])
    else $error("precharge too soon after activate");
  chk_rp_delay: assert property (mem_cmd != SDTC_CMD_NOP |-> pre_ff > trp_ff)
    else $error("command too soon after precharge");
  chk_rc_delay: assert property (mem_cmd == SDTC_CMD_ACT |-> ref_ff > trc_ff)
    else $error("activate too soon after refresh");
endmodule // sdtc_core_asserts

bind sdtc_core sdtc_core_asserts sdtc_core_asserts_inst (.sys_clk, .rst_b, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .pslverr, .mem_cmd, .mem_clock_enable_out, .mem_clock_run);
`default_nettype wire

// >>> sim/sdtc_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module sdtc_mem_model
  import sdtc_pkg::*;
(
  // Clock and reset.
  input  wire logic      sys_clk,
  input  wire logic      rst_b,
  // Command pins from the controller.
  input  wire sdtc_cmd_e mem_cmd,
  input  wire logic      mem_clock_enable_out,
  // What the memory has seen.
  output logic [15:0]    ref_count,
  output logic [1:0]     sleep_mode,
  output logic           cmd_lost
);
  // A sleeping memory ignores commands, so any command then is lost.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ref_count  <= 16'h0000;
      sleep_mode <= 2'h0;
      cmd_lost   <= 1'b0;
    end else begin
      if (mem_cmd == SDTC_CMD_REF) ref_count <= ref_count + 16'h0001;
      if (mem_cmd == SDTC_CMD_SREF) sleep_mode <= 2'h1;
      else if (mem_cmd == SDTC_CMD_PDN) sleep_mode <= 2'h2;
      else if (mem_cmd == SDTC_CMD_DPD) sleep_mode <= 2'h3;
      else if (mem_clock_enable_out) sleep_mode <= 2'h0;
      if (sleep_mode != 2'h0 && !mem_clock_enable_out && mem_cmd != SDTC_CMD_NOP) cmd_lost <= 1'b1;
    end
  end
endmodule // sdtc_mem_model
`default_nettype wire

// >>> sim/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "sdtc_regs.svh"
module tb_top;
  import sdtc_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, acc_req = 1'b0, acc_write = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, d;
  logic        pready, pslverr, slv, acc_done, mem_clock_enable_out, mem_clock_run;
  logic        refresh_error_flag, refresh_irq_mask, cmd_lost;
  sdtc_cmd_e   mem_cmd;
  sdtc_geom_s  geom;
  sdtc_ext_s   ext_mode;
  logic [15:0] ref_count;
  logic [1:0]  sleep_mode, m, to;
  int          err_total = 0, check_count = 0, cyc = 0, t;
  logic [7:0]  adr [6] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h1C, 8'h20};
  logic [31:0] rst [6] = '{32'h0, 32'h0, 32'h852372C0, 32'h0, 32'h0, 32'h0};

  always #4 sys_clk = ~sys_clk;

  sdtc_core sdtc_core_inst (.sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .acc_req, .acc_write, .acc_done, .mem_cmd,
    .mem_clock_enable_out, .mem_clock_run, .geom, .ext_mode, .refresh_error_flag,
    .refresh_irq_mask);
  sdtc_mem_model sdtc_mem_model_inst (.sys_clk, .rst_b, .mem_cmd, .mem_clock_enable_out,
    .ref_count, .sleep_mode, .cmd_lost);

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic apb(logic w, logic [7:0] a, logic [31:0] v);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic acc(logic w);
    int n;
    n = 0;
    acc_req <= 1'b1;
    acc_write <= w;
    do begin @(posedge sys_clk); n++; end while (acc_done !== 1'b1 && n < 400);
    check("acc_done", acc_done, 1'b1);
    acc_req <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wait_sleep(logic [1:0] s);
    for (int n = 0; n < 40 && sleep_mode !== s; n++) @(posedge sys_clk);
  endtask

  task automatic wait_ref(output int n);
    n = 0;
    do begin @(posedge sys_clk); n++; end while (mem_cmd !== SDTC_CMD_REF && n < 9000);
  endtask

  function automatic sdtc_geom_s geo_exp(logic [7:0] c);
    return {4'h8 + {2'h0, c[1:0]}, 4'hB + {2'h0, c[3:2]}, c[4] ? 3'h4 : 3'h2, c[6:5],
      c[7] ? 6'h10 : 6'h20};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hAA87FADF));
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    foreach (adr[i]) begin
      apb(1'b0, adr[i], 32'h0);
      check("reset value", rd, rst[i]);
      check("pslverr", slv, i == 0);
    end
    check("geom reset", 32'(geom), 32'(geo_exp(8'hC0)));
    repeat (100) @(posedge sys_clk);
    check("early refresh", ref_count, 32'h0);
    for (int i = 0; i < 4; i++) begin
      d = $urandom();
      d[7:0] = {i[1], 2'(i % 3 + 1), i[0], 2'(i % 3), 2'(i)};
      apb(1'b1, `SDTC_OFS_GEOMETRY, d);
      apb(1'b0, `SDTC_OFS_GEOMETRY, 32'h0);
      check("geometry", rd, d);
      check("geom", 32'(geom), 32'(geo_exp(d[7:0])));
      acc(i[0]);
    end
    apb(1'b1, `SDTC_OFS_GEOMETRY, `SDTC_RST_GEOMETRY);
    apb(1'b1, `SDTC_OFS_REFRESH, 32'h28);
    wait_ref(t);
    wait_ref(t);
    check("refresh gap", t, 41);
    wait_ref(t);
    check("refresh gap", t, 41);
    // A count of one overruns every refresh and must flag an error.
    apb(1'b1, `SDTC_OFS_REFRESH, 32'h1);
    repeat (30) @(posedge sys_clk);
    apb(1'b1, `SDTC_OFS_REFRESH, 32'hFFF);
    check("error port", refresh_error_flag, 1'b1);
    apb(1'b0, `SDTC_OFS_IRQ_STAT, 32'h0);
    check("status", rd, 32'h1);
    apb(1'b0, `SDTC_OFS_IRQ_STAT, 32'h0);
    check("status", rd, 32'h0);
    check("error port", refresh_error_flag, 1'b0);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, (i < 2) ? `SDTC_OFS_IRQ_EN : `SDTC_OFS_IRQ_DIS, 32'(i % 2));
      apb(1'b0, `SDTC_OFS_IRQ_MASK, 32'h0);
      check("mask", rd, i == 1 || i == 2);
      check("mask port", refresh_irq_mask, i == 1 || i == 2);
    end
    for (int i = 0; i < 5; i++) begin
      m = 2'(i % 3 + 1);
      to = (i < 3) ? 2'h0 : 2'(i - 2);
      apb(1'b1, `SDTC_OFS_LOWPOWER, 32'h0);
      wait_sleep(2'h0);
      d = $urandom() & 32'h0F70;
      d[1:0] = m;
      d[13:12] = to;
      apb(1'b1, `SDTC_OFS_LOWPOWER, d);
      apb(1'b0, `SDTC_OFS_LOWPOWER, 32'h0);
      check("low power", rd, d);
      check("ext mode", 32'(ext_mode), 32'({d[6:4], d[9:8], d[11:10]}));
      if (m != 2'h3) acc(i[0]);
      if (to != 2'h0) begin
        repeat (64 * to - 8) @(posedge sys_clk);
        check("early sleep", sleep_mode, 32'h0);
      end
      wait_sleep(m);
      check("sleep", sleep_mode, m);
      check("cke", mem_clock_enable_out, 1'b0);
      if (m == 2'h1) check("clock run", mem_clock_run, 1'b0);
      if (m != 2'h3 && to == 2'h0) begin
        acc(1'b1);
        wait_sleep(m);
        check("sleep again", sleep_mode, m);
      end
    end
    apb(1'b1, `SDTC_OFS_LOWPOWER, 32'h0);
    wait_sleep(2'h0);
    check("awake", sleep_mode, 32'h0);
    check("lost command", cmd_lost, 1'b0);
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
